/* File: inc/sac_pkg.sv */
// Behaviour
// - Regeneration overload raises 18.0, logged, stop.
// - Regeneration transistor fault raises 18.1, logged.
// - Encoder wiring disconnected raises 21.0, logged.
// - Encoder communication error raises 21.1, logged.
// - Encoder link silent raises 23.0, logged.
// - Position error over limit raises 24.0.
// - Full-closed hybrid error over limit raises 25.0.
// - Speed over overspeed limit raises 26.0.
// - Speed over stop-overspeed limit raises 26.1.
// - Multi-turn counter cleared raises 27.1, logged.
// - Command step over limit raises 27.4.
// - Command arithmetic error raises 27.5.
// - Fieldbus up during trial raises 27.6.
// - Init position over gear ratio overflow raises 29.1.
// - Error or command magnitude overflow raises 29.2.
// - Homing distance times gear overflow raises 29.3.
// - Safety input off raises 30.0, clearable.
// - Duplicate function among inputs a-d raises 33.0.
// - Any alarm: output on, drive off, display.
// - Clearable alarms reset by request; others by power.
package sac_pkg;

  localparam int          SAC_NUM_ALARMS = 18;
  localparam int          SAC_HIST_DEPTH = 4;

  localparam logic [7:0]  SAC_ADDR_STATUS     = 8'h00;
  localparam logic [7:0]  SAC_ADDR_PENDING    = 8'h04;
  localparam logic [7:0]  SAC_ADDR_CLEAR      = 8'h08;
  localparam logic [7:0]  SAC_ADDR_ERR_LIM    = 8'h0C;
  localparam logic [7:0]  SAC_ADDR_HYB_LIM    = 8'h10;
  localparam logic [7:0]  SAC_ADDR_OVS_LIM    = 8'h14;
  localparam logic [7:0]  SAC_ADDR_EOVS_LIM   = 8'h18;
  localparam logic [7:0]  SAC_ADDR_STEP_LIM   = 8'h1C;
  localparam logic [7:0]  SAC_ADDR_HOME_DIST  = 8'h20;
  localparam logic [7:0]  SAC_ADDR_GEAR       = 8'h24;
  localparam logic [7:0]  SAC_ADDR_CTRL       = 8'h28;
  localparam logic [7:0]  SAC_ADDR_HIST_CNT   = 8'h2C;
  localparam logic [7:0]  SAC_ADDR_HIST_BASE  = 8'h30;

  localparam logic [31:0] SAC_RST_ERR_LIM   = 32'h0010_0000;
  localparam logic [31:0] SAC_RST_HYB_LIM   = 32'h0001_0000;
  localparam logic [31:0] SAC_RST_OVS_LIM   = 32'h0000_1770;
  localparam logic [31:0] SAC_RST_EOVS_LIM  = 32'h0000_1B58;
  localparam logic [31:0] SAC_RST_STEP_LIM  = 32'h0000_8000;
  localparam logic [31:0] SAC_RST_HOME_DIST = 32'h0000_0000;
  localparam logic [31:0] SAC_RST_GEAR      = 32'h0001_0001;
  localparam logic [31:0] SAC_RST_CTRL      = 32'h0000_0000;

  localparam logic [32:0] SAC_LIM_2P31 = 33'h0_8000_0000;
  localparam logic [31:0] SAC_LIM_2P29 = 32'h2000_0000;
  localparam logic [31:0] SAC_LIM_2P30 = 32'h4000_0000;

  localparam int          SAC_STAT_ACTIVE = 31;
  localparam int          SAC_STAT_MAIN   = 16;
  localparam int          SAC_STAT_SUB    = 8;
  localparam int          SAC_CTRL_FULLCL = 0;
  localparam int          SAC_CLEAR_REQ   = 0;

  typedef struct packed {
    logic [7:0] main_code;
    logic [7:0] sub_code;
    logic       history;
    logic       clearable;
    logic       estop;
  } sac_attr_t;

  typedef struct packed {
    logic               regen_overload;
    logic               regen_tr_fault;
    logic               enc_disconnect;
    logic               enc_comm_error;
    logic               enc_no_comm;
    logic               abs_turns_cleared;
    logic               cmd_calc_error;
    logic               fieldbus_up;
    logic               trial_running;
    logic               safety_input;
    logic               pos_init_strobe;
    logic signed [31:0] pos_error_pulses;
    logic signed [31:0] pos_cmd_units;
    logic signed [31:0] hybrid_error;
    logic signed [31:0] motor_speed;
    logic signed [31:0] cmd_step;
    logic signed [31:0] abs_position;
    logic [5:0]         general_input_a;
    logic [5:0]         general_input_b;
    logic [5:0]         general_input_c;
    logic [5:0]         general_input_d;
  } sac_sense_t;

  localparam sac_attr_t SAC_TABLE [SAC_NUM_ALARMS] = '{
    '{8'h12, 8'h00, 1'b1, 1'b0, 1'b1},
    '{8'h12, 8'h01, 1'b1, 1'b0, 1'b0},
    '{8'h15, 8'h00, 1'b1, 1'b0, 1'b0},
    '{8'h15, 8'h01, 1'b1, 1'b0, 1'b0},
    '{8'h17, 8'h00, 1'b1, 1'b0, 1'b0},
    '{8'h18, 8'h00, 1'b1, 1'b1, 1'b1},
    '{8'h19, 8'h00, 1'b1, 1'b0, 1'b1},
    '{8'h1A, 8'h00, 1'b1, 1'b1, 1'b1},
    '{8'h1A, 8'h01, 1'b1, 1'b1, 1'b0},
    '{8'h1B, 8'h01, 1'b1, 1'b0, 1'b0},
    '{8'h1B, 8'h04, 1'b1, 1'b0, 1'b0},
    '{8'h1B, 8'h05, 1'b1, 1'b0, 1'b0},
    '{8'h1B, 8'h06, 1'b1, 1'b1, 1'b0},
    '{8'h1D, 8'h01, 1'b1, 1'b0, 1'b0},
    '{8'h1D, 8'h02, 1'b1, 1'b0, 1'b0},
    '{8'h1D, 8'h03, 1'b1, 1'b0, 1'b0},
    '{8'h1E, 8'h00, 1'b0, 1'b1, 1'b0},
    '{8'h21, 8'h00, 1'b1, 1'b0, 1'b0}
  };

  function automatic logic [31:0] sac_mag(input logic signed [31:0] v);
    sac_mag = v[31] ? 32'(-v) : 32'(v);
  endfunction : sac_mag

endpackage : sac_pkg

/* File: src/sac_servo_alarm_classifier.sv */
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module sac_servo_alarm_classifier (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire sac_pkg::sac_sense_t sense,
  input  wire logic              fieldbus_reset_req,
  output logic                   alarm_output,
  output logic                   drive_enable,
  output logic                   estop_request,
  output logic [7:0]             display_main,
  output logic [7:0]             display_sub
);
  import sac_pkg::*;

  logic [31:0]               err_lim_q;
  logic [31:0]               hyb_lim_q;
  logic [31:0]               ovs_lim_q;
  logic [31:0]               eovs_lim_q;
  logic [31:0]               step_lim_q;
  logic [31:0]               home_dist_q;
  logic [31:0]               gear_q;
  logic [31:0]               ctrl_q;
  logic [SAC_NUM_ALARMS-1:0] pending_q;
  logic [SAC_NUM_ALARMS-1:0] logged_q;
  logic [SAC_NUM_ALARMS-1:0] cause;
  logic [SAC_NUM_ALARMS-1:0] clr_mask;
  logic [15:0]               hist_q [SAC_HIST_DEPTH];
  logic [1:0]                hist_wp_q;
  logic [7:0]                hist_cnt_q;
  logic                      safety_q;
  logic                      fieldbus_q;
  logic                      apb_setup;
  logic                      apb_wr;
  logic                      clear_req;
  logic                      mapped;
  logic [31:0]               rd_d;
  logic                      act_valid;
  logic [4:0]                act_idx;
  logic                      log_valid;
  logic [4:0]                log_idx;
  logic                      any_estop;
  logic [15:0]               gear_num;
  logic [15:0]               gear_den;
  logic [47:0]               init_lhs;
  logic [47:0]               init_rhs;
  logic [47:0]               home_lhs;
  logic [47:0]               home_rhs;
  logic                      dup_alloc;

  assign gear_num = gear_q[15:0];
  assign gear_den = gear_q[31:16];

  // Zero-wait slave: the access phase always completes in its first cycle.
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;

  // Shared by the clear strobe and every limit register so all writes decode the same way.
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] offset);
    wr_hit = wr && (addr == offset);
  endfunction : wr_hit

  // Ratio checks are done by cross multiplication so no divider is needed.
  assign init_lhs = 48'(sac_mag(sense.abs_position)) * 48'(gear_den);
  assign init_rhs = 48'(SAC_LIM_2P31) * 48'(gear_num);
  assign home_lhs = 48'(sac_mag(home_dist_q)) * 48'(gear_num);
  assign home_rhs = 48'(SAC_LIM_2P31) * 48'(gear_den);

  // An unassigned slot (function code zero) never counts as a duplicate.
  always_comb begin
    logic [5:0] f [4];
    f[0] = sense.general_input_a;
    f[1] = sense.general_input_b;
    f[2] = sense.general_input_c;
    f[3] = sense.general_input_d;
    dup_alloc = 1'b0;
    for (int i = 0; i < 4; i++) begin
      for (int j = i + 1; j < 4; j++) begin
        if (f[i] != 6'h00 && f[i] == f[j]) begin
          dup_alloc = 1'b1;
        end
      end
    end
  end

  always_comb begin
    cause     = '0;
    cause[0]  = sense.regen_overload;
    cause[1]  = sense.regen_tr_fault;
    cause[2]  = sense.enc_disconnect;
    cause[3]  = sense.enc_comm_error;
    cause[4]  = sense.enc_no_comm;
    cause[5]  = sac_mag(sense.pos_error_pulses) > err_lim_q;
    cause[6]  = ctrl_q[SAC_CTRL_FULLCL] & (sac_mag(sense.hybrid_error) > hyb_lim_q);
    cause[7]  = sac_mag(sense.motor_speed) > ovs_lim_q;
    cause[8]  = sac_mag(sense.motor_speed) > eovs_lim_q;
    cause[9]  = sense.abs_turns_cleared;
    cause[10] = sac_mag(sense.cmd_step) > step_lim_q;
    cause[11] = sense.cmd_calc_error;
    cause[12] = sense.fieldbus_up & ~fieldbus_q & sense.trial_running;
    cause[13] = sense.pos_init_strobe & (init_lhs > init_rhs);
    cause[14] = (sac_mag(sense.pos_error_pulses) > SAC_LIM_2P29) |
                (sac_mag(sense.pos_cmd_units) > SAC_LIM_2P30);
    cause[15] = home_lhs > home_rhs;
    cause[16] = safety_q & ~sense.safety_input;
    cause[17] = dup_alloc;
  end

  assign clear_req = fieldbus_reset_req |
                     (wr_hit(apb_wr, paddr, SAC_ADDR_CLEAR) && pwdata[SAC_CLEAR_REQ]);

  always_comb begin
    for (int i = 0; i < SAC_NUM_ALARMS; i++) begin
      clr_mask[i] = clear_req & SAC_TABLE[i].clearable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_q <= 1'b0;
    end else begin
      safety_q <= sense.safety_input;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fieldbus_q <= 1'b0;
    end else begin
      fieldbus_q <= sense.fieldbus_up;
    end
  end

  // A new cause in the clear cycle keeps its alarm; non-clearable ones only drop at reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= '0;
    end else begin
      pending_q <= (pending_q & ~clr_mask) | cause;
    end
  end

  always_comb begin
    act_valid = 1'b0;
    act_idx   = 5'h00;
    log_valid = 1'b0;
    log_idx   = 5'h00;
    any_estop = 1'b0;
    for (int i = SAC_NUM_ALARMS - 1; i >= 0; i--) begin
      if (pending_q[i]) begin
        act_valid = 1'b1;
        act_idx   = 5'(i);
        any_estop = any_estop | SAC_TABLE[i].estop;
      end
      if (pending_q[i] && !logged_q[i] && SAC_TABLE[i].history) begin
        log_valid = 1'b1;
        log_idx   = 5'(i);
      end
    end
  end

  // One history entry per cycle; alarms raised together are logged on successive cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      logged_q <= '0;
    end else begin
      for (int i = 0; i < SAC_NUM_ALARMS; i++) begin
        if (log_valid && log_idx == 5'(i)) begin
          logged_q[i] <= 1'b1;
        end else if (!pending_q[i]) begin
          logged_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_wp_q  <= 2'h0;
      hist_cnt_q <= 8'h00;
      for (int i = 0; i < SAC_HIST_DEPTH; i++) begin
        hist_q[i] <= 16'h0000;
      end
    end else if (log_valid) begin
      hist_q[hist_wp_q] <= {SAC_TABLE[log_idx].main_code, SAC_TABLE[log_idx].sub_code};
      hist_wp_q         <= hist_wp_q + 2'h1;
      if (hist_cnt_q != 8'hFF) begin
        hist_cnt_q <= hist_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_output <= 1'b0;
    end else begin
      alarm_output <= act_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_enable <= 1'b0;
    end else begin
      drive_enable <= ~act_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      estop_request <= 1'b0;
    end else begin
      estop_request <= any_estop;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_main <= 8'h00;
    end else begin
      display_main <= act_valid ? SAC_TABLE[act_idx].main_code : 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_sub <= 8'h00;
    end else begin
      display_sub <= act_valid ? SAC_TABLE[act_idx].sub_code : 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_lim_q <= SAC_RST_ERR_LIM;
    end else if (wr_hit(apb_wr, paddr, SAC_ADDR_ERR_LIM)) begin
      err_lim_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hyb_lim_q <= SAC_RST_HYB_LIM;
    end else if (wr_hit(apb_wr, paddr, SAC_ADDR_HYB_LIM)) begin
      hyb_lim_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovs_lim_q <= SAC_RST_OVS_LIM;
    end else if (wr_hit(apb_wr, paddr, SAC_ADDR_OVS_LIM)) begin
      ovs_lim_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eovs_lim_q <= SAC_RST_EOVS_LIM;
    end else if (wr_hit(apb_wr, paddr, SAC_ADDR_EOVS_LIM)) begin
      eovs_lim_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_lim_q <= SAC_RST_STEP_LIM;
    end else if (wr_hit(apb_wr, paddr, SAC_ADDR_STEP_LIM)) begin
      step_lim_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      home_dist_q <= SAC_RST_HOME_DIST;
    end else if (wr_hit(apb_wr, paddr, SAC_ADDR_HOME_DIST)) begin
      home_dist_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gear_q <= SAC_RST_GEAR;
    end else if (wr_hit(apb_wr, paddr, SAC_ADDR_GEAR)) begin
      gear_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= SAC_RST_CTRL;
    end else if (wr_hit(apb_wr, paddr, SAC_ADDR_CTRL)) begin
      ctrl_q <= {31'h0000_0000, pwdata[SAC_CTRL_FULLCL]};
    end
  end

  always_comb begin
    rd_d   = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      SAC_ADDR_STATUS: begin
        rd_d[SAC_STAT_ACTIVE] = act_valid;
        if (act_valid) begin
          rd_d[SAC_STAT_MAIN +: 8] = SAC_TABLE[act_idx].main_code;
          rd_d[SAC_STAT_SUB +: 8]  = SAC_TABLE[act_idx].sub_code;
          rd_d[2:0] = {SAC_TABLE[act_idx].estop, SAC_TABLE[act_idx].clearable, SAC_TABLE[act_idx].history};
        end
      end
      SAC_ADDR_PENDING:   rd_d = 32'(pending_q);
      SAC_ADDR_CLEAR:     rd_d = 32'h0000_0000;
      SAC_ADDR_ERR_LIM:   rd_d = err_lim_q;
      SAC_ADDR_HYB_LIM:   rd_d = hyb_lim_q;
      SAC_ADDR_OVS_LIM:   rd_d = ovs_lim_q;
      SAC_ADDR_EOVS_LIM:  rd_d = eovs_lim_q;
      SAC_ADDR_STEP_LIM:  rd_d = step_lim_q;
      SAC_ADDR_HOME_DIST: rd_d = home_dist_q;
      SAC_ADDR_GEAR:      rd_d = gear_q;
      SAC_ADDR_CTRL:      rd_d = ctrl_q;
      SAC_ADDR_HIST_CNT:  rd_d = {24'h00_0000, hist_cnt_q};
      SAC_ADDR_HIST_BASE + 8'h00: rd_d = {16'h0000, hist_q[0]};
      SAC_ADDR_HIST_BASE + 8'h04: rd_d = {16'h0000, hist_q[1]};
      SAC_ADDR_HIST_BASE + 8'h08: rd_d = {16'h0000, hist_q[2]};
      SAC_ADDR_HIST_BASE + 8'h0C: rd_d = {16'h0000, hist_q[3]};
      default:            mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so prdata comes from a flop yet needs no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~mapped;
      if (apb_setup && !pwrite) begin
        prdata <= mapped ? rd_d : 32'h0000_0000;
      end
    end
  end

endmodule : sac_servo_alarm_classifier

/* File: test/sac_host_model.sv */
`timescale 1ns/100ps
module sac_host_model (
  input  wire logic  pclk,
  input  wire logic  pready,
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic       fieldbus_reset_req
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fieldbus_reset_req} = '0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so that a stale address or data word can never pass for a live one.
    paddr  <= ~a;
    pwdata <= ~d;
  endtask : xfer

  task automatic fb_reset();
    @(posedge pclk);
    fieldbus_reset_req <= 1'b1;
    @(posedge pclk);
    fieldbus_reset_req <= 1'b0;
  endtask : fb_reset
endmodule : sac_host_model

/* File: test/sac_servo_alarm_classifier_assertions.sv */
`timescale 1ns/100ps
module sac_servo_alarm_classifier_assertions (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire sac_pkg::sac_sense_t sense,
  input wire logic                alarm_output,
  input wire logic                drive_enable,
  input wire logic                estop_request,
  input wire logic [7:0]          display_main
);
  import sac_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_busy; alarm_output |-> !drive_enable && display_main != 8'h00; endproperty
  a_busy: assert property (p_busy) else $error("alarm without drive off or code");
  property p_idle; !alarm_output |-> display_main == 8'h00 && !estop_request; endproperty
  a_idle: assert property (p_idle) else $error("code or stop without alarm");
  property p_regen; sense.regen_overload |-> ##2 alarm_output && estop_request; endproperty
  a_regen: assert property (p_regen) else $error("regeneration overload not stopping");
  // A wiring fault must survive any clear request, so the alarm stays up across eight cycles.
  property p_hold; sense.enc_disconnect |-> ##2 alarm_output [*8]; endproperty
  a_hold: assert property (p_hold) else $error("wiring alarm dropped");
  // The sample before release is ignored because the stored safety level restarts low.
  property p_safety; $fell(sense.safety_input) && $past(presetn) |-> ##2 alarm_output; endproperty
  a_safety: assert property (p_safety) else $error("safety off not alarmed");
  property p_dup;
    sense.general_input_a != 6'h00 && sense.general_input_a == sense.general_input_b |-> ##2 alarm_output;
  endproperty
  a_dup: assert property (p_dup) else $error("duplicate input function not alarmed");
endmodule : sac_servo_alarm_classifier_assertions

bind sac_servo_alarm_classifier sac_servo_alarm_classifier_assertions u_chk (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .sense, .alarm_output, .drive_enable, .estop_request,
  .display_main
);

/* File: test/sac_servo_alarm_classifier_tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("FAIL %s expected %0h seen %0h", n, e, g); end end
module sac_servo_alarm_classifier_tb_top;
  import sac_pkg::*;
  localparam logic [18:0] EXP_TAB [18] = '{
    {8'h12, 8'h00, 3'b101}, {8'h12, 8'h01, 3'b001}, {8'h15, 8'h00, 3'b001}, {8'h15, 8'h01, 3'b001},
    {8'h17, 8'h00, 3'b001}, {8'h18, 8'h00, 3'b111}, {8'h19, 8'h00, 3'b101}, {8'h1A, 8'h00, 3'b111},
    {8'h1A, 8'h01, 3'b011}, {8'h1B, 8'h01, 3'b001}, {8'h1B, 8'h04, 3'b001}, {8'h1B, 8'h05, 3'b001},
    {8'h1B, 8'h06, 3'b011}, {8'h1D, 8'h01, 3'b001}, {8'h1D, 8'h02, 3'b001}, {8'h1D, 8'h03, 3'b001},
    {8'h1E, 8'h00, 3'b010}, {8'h21, 8'h00, 3'b001}};
  localparam logic [39:0] RST_TAB [8] = '{{SAC_ADDR_ERR_LIM, SAC_RST_ERR_LIM}, {SAC_ADDR_HYB_LIM, SAC_RST_HYB_LIM},
    {SAC_ADDR_OVS_LIM, SAC_RST_OVS_LIM}, {SAC_ADDR_EOVS_LIM, SAC_RST_EOVS_LIM}, {SAC_ADDR_STEP_LIM, SAC_RST_STEP_LIM},
    {SAC_ADDR_HOME_DIST, SAC_RST_HOME_DIST}, {SAC_ADDR_GEAR, SAC_RST_GEAR}, {SAC_ADDR_CTRL, SAC_RST_CTRL}};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fieldbus_reset_req;
  logic        alarm_output, drive_enable, estop_request;
  logic [7:0]  paddr, display_main, display_sub, lfsr;
  logic [31:0] pwdata, prdata;
  logic [17:0] pend, m;
  logic [15:0] hist [4];
  logic [32:0] exp_q [$];
  sac_sense_t  sense;
  int          bad_count, checked, hcnt, cyc;

  sac_servo_alarm_classifier dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sense, .fieldbus_reset_req, .alarm_output, .drive_enable, .estop_request, .display_main,
    .display_sub);
  sac_host_model host (.pclk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata, .fieldbus_reset_req);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] big(input logic [31:0] base);
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    big = lfsr[0] ? -(base + lfsr) : base + lfsr;
  endfunction : big

  task automatic wrap_up();
    $display("Counts: checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    host.xfer(w, a, d);
  endtask : bus

  task automatic expect_state();
    int   k;
    logic e;
    k = -1;
    e = 1'b0;
    for (int j = 17; j >= 0; j--) begin
      if (pend[j]) k = j;
      e = e | (pend[j] & EXP_TAB[j][2]);
    end
    repeat (3) @(posedge pclk);
    bus(1'b0, SAC_ADDR_PENDING, 32'h0, {15'h0, pend});
    bus(1'b0, SAC_ADDR_STATUS, 32'h0, (k < 0) ? 33'h0 : {2'h1, 7'h0, EXP_TAB[k][18:3], 5'h0, EXP_TAB[k][2:0]});
    `CHK("alarm_output", |pend, alarm_output)
    `CHK("drive_enable", ~|pend, drive_enable)
    `CHK("display_main", (k < 0) ? 8'h00 : EXP_TAB[k][18:11], display_main)
    `CHK("display_sub", (k < 0) ? 8'h00 : EXP_TAB[k][10:3], display_sub)
    `CHK("estop_request", e, estop_request)
  endtask : expect_state

  task automatic cause(input int i, input logic on);
    case (i)
      0: sense.regen_overload <= on;
      1: sense.regen_tr_fault <= on;
      2: sense.enc_disconnect <= on;
      3: sense.enc_comm_error <= on;
      4: sense.enc_no_comm <= on;
      5: sense.pos_error_pulses <= on ? big(32'h0010_0001) : 32'h0;
      6: sense.hybrid_error <= on ? big(32'h0001_0001) : 32'h0;
      7: sense.motor_speed <= on ? big(32'h0000_1771) : 32'h0;
      8: sense.motor_speed <= on ? big(32'h0000_1B59) : 32'h0;
      9: sense.abs_turns_cleared <= on;
      10: sense.cmd_step <= on ? big(32'h0000_8001) : 32'h0;
      11: sense.cmd_calc_error <= on;
      12: sense.fieldbus_up <= on;
      13: begin
        bus(1'b1, SAC_ADDR_GEAR, 32'h0002_0001, 33'h0);
        sense.abs_position <= big(32'h4000_0001);
        sense.pos_init_strobe <= on;
      end
      14: sense.pos_cmd_units <= on ? big(32'h4000_0001) : 32'h0;
      15: begin
        bus(1'b1, SAC_ADDR_GEAR, 32'h0001_0004, 33'h0);
        bus(1'b1, SAC_ADDR_HOME_DIST, on ? big(32'h2000_0001) : 32'h0, 33'h0);
      end
      16: sense.safety_input <= !on;
      default: begin
        sense.general_input_a <= on ? 6'h05 : 6'h00;
        sense.general_input_b <= on ? 6'h05 : 6'h00;
      end
    endcase
  endtask : cause

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      `CHK("pslverr", exp_q[0][32], pslverr)
      if (!pwrite) `CHK("prdata", exp_q[0][31:0], prdata)
      void'(exp_q.pop_front());
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    presetn = 1'b0;
    sense = '0;
    sense.general_input_c = 6'h01;
    sense.general_input_d = 6'h02;
    lfsr = 8'h3D;
    pend = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    sense.safety_input <= 1'b1;
    sense.trial_running <= 1'b1;
    foreach (RST_TAB[i]) bus(1'b0, RST_TAB[i][39:32], 32'h0, {1'b0, RST_TAB[i][31:0]});
    bus(1'b0, 8'hF0, 32'h0, {1'b1, 32'h0});
    bus(1'b1, 8'hF0, 32'h0, {1'b1, 32'h0});
    bus(1'b1, SAC_ADDR_STATUS, 32'hFFFF_FFFF, 33'h0);
    bus(1'b1, SAC_ADDR_CTRL, 32'h0000_0001, 33'h0);
    expect_state();
    // Lowest index wins the display, so alarms go in from the top and each new one becomes visible, except 26.1 (index 8), whose speed also raises 26.0 (index 7).
    for (int i = 17; i >= 0; i--) begin
      m = (18'h1 << i) | ((i == 8) ? 18'h80 : 18'h0);
      cause(i, 1'b1);
      for (int j = 0; j < 18; j++) begin
        if (m[j] && !pend[j] && EXP_TAB[j][0]) begin
          hist[hcnt % 4] = EXP_TAB[j][18:3];
          hcnt++;
        end
      end
      pend = pend | m;
      expect_state();
      cause(i, 1'b0);
      if (i % 2) host.fb_reset();
      else bus(1'b1, SAC_ADDR_CLEAR, 32'h0000_0001, 33'h0);
      for (int j = 0; j < 18; j++) if (EXP_TAB[j][1]) pend[j] = 1'b0;
      expect_state();
    end
    bus(1'b0, SAC_ADDR_HIST_CNT, 32'h0, {1'b0, 32'(hcnt)});
    for (int j = 0; j < 4; j++) bus(1'b0, SAC_ADDR_HIST_BASE + 8'(4 * j), 32'h0, {17'h0, hist[j]});
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    pend = '0;
    expect_state();
    wrap_up();
  end
endmodule : sac_servo_alarm_classifier_tb_top
